// >>> core/bcs_block_clock.sv
// Top: block clock selection, power-up init and AHB-Lite configuration
//
// What this block does
// - Four global clock pins, each also usable as a plain logic input.
// - Each block generates four local clocks usable by any cell there.
// - Each local clock uses the true or complement edge of its global clock.
// - Locals 0/1 draw from globals 0/1, locals 2/3 from globals 2/3.
// - Two-pin parts tie global 2 to global 0 and 3 to 1.
// - Local clocks let latches use either enable polarity, master-slave too.
// - Each pin has a weak keeper holding the last actively driven level.
// - All pin keepers start holding logic high at power-up.
// - One bit chooses pull-up or keeper behaviour for every pin.
// - Each block has its own low-power option that makes it slower.
// - Cells configured for set come up set at power-up.
// - Cells configured for reset only, or neither, come up cleared.
// - Swapping reset and preset also swaps the power-up value.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`default_nettype none

module bcs_block_clock
    import bcs_pkg::*;
#(
    parameter int N_CELLS = 8,
    parameter int N_PINS = 8,
    parameter bit TWO_PIN_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Global clock pins
    input wire logic [3:0] global_clock_pin,
    output logic [3:0] global_pin_logic,
    output logic [3:0] local_clock_level,
    // Storage cells of the block
    input wire logic block_preset,
    input wire logic block_reset,
    input wire logic [N_CELLS-1:0] cell_d,
    output logic [N_CELLS-1:0] cell_q,
    output logic init_done,
    // Pin keepers
    input wire logic [N_PINS-1:0] pad_in,
    input wire logic [N_PINS-1:0] pad_driven,
    output logic [N_PINS-1:0] keep_out,
    output logic [N_PINS-1:0] keep_oe_n
);

    generate
        if (N_CELLS < 1 || N_CELLS > 8) begin : g_bad_cells
            $error("N_CELLS must lie between 1 and 8");
        end
        if (N_PINS < 1 || N_PINS > 16) begin : g_bad_pins
            $error("N_PINS must lie between 1 and 16");
        end
    endgenerate

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic addr_valid;
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] clksel_reg;
    logic [31:0] clksel_next;
    logic [31:0] cell_init_reg;
    logic [31:0] cell_init_next;
    logic [31:0] cell_clk_reg;
    logic [31:0] cell_clk_next;
    logic [N_PINS-1:0] pad_level;
    logic locked;
    bcs_init_state_type state_reg;
    bcs_init_state_type state_next;
    logic [DELAY_CNT_W-1:0] cnt_reg;
    logic [DELAY_CNT_W-1:0] cnt_next;
    logic [N_CELLS-1:0] cell_q_reg;
    logic [N_CELLS-1:0] lp_q_reg;
    logic [N_CELLS-1:0] eff_set;
    logic [N_CELLS-1:0] eff_rst;
    wire [N_CELLS-1:0] cell_next;

    // Zero wait states: every transfer completes in its data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign addr_valid = hsel && htrans[1] && hready;
    assign locked = ctrl_reg[CTRL_LOCK_BIT];

    // Read mux; unmapped offsets read zero
    function automatic logic [31:0] rd_value(input logic [31:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a[31:8] == 24'h00_0000) begin
            unique case (a[7:0])
                ADDR_CTRL: v = ctrl_reg;
                ADDR_CLKSEL: v = clksel_reg;
                ADDR_CELL_INIT: v = cell_init_reg;
                ADDR_CELL_CLK: v = cell_clk_reg;
                ADDR_STATUS: v = {16'h0000, 8'(cell_q), 3'b000, init_done,
                    local_clock_level};
                ADDR_PIN_STATUS: v = 32'(pad_level);
                default: v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction : rd_value

    // Config writes land in the data phase; after lock they are dropped
    always_comb begin
        wr_pend_next = addr_valid && hwrite && (haddr[31:8] == 24'h00_0000);
        wr_addr_next = haddr[7:0];
        hrdata_next = (addr_valid && !hwrite) ? rd_value(haddr) : hrdata_reg;
        ctrl_next = ctrl_reg;
        clksel_next = clksel_reg;
        cell_init_next = cell_init_reg;
        cell_clk_next = cell_clk_reg;
        if (wr_pend_reg && !locked) begin
            unique case (wr_addr_reg)
                ADDR_CTRL: ctrl_next = hwdata & 32'h0000_00F7;
                ADDR_CLKSEL: clksel_next = hwdata & 32'h0000_00FF;
                ADDR_CELL_INIT: cell_init_next = hwdata & 32'h00FF_FFFF;
                ADDR_CELL_CLK: cell_clk_next = hwdata & 32'h00FF_FFFF;
                default: ;
            endcase
        end
    end

    // Bus and configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
            ctrl_reg <= CTRL_RESET;
            clksel_reg <= CLKSEL_RESET;
            cell_init_reg <= CELL_INIT_RESET;
            cell_clk_reg <= CELL_CLK_RESET;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg <= hrdata_next;
            ctrl_reg <= ctrl_next;
            clksel_reg <= clksel_next;
            cell_init_reg <= cell_init_next;
            cell_clk_reg <= cell_clk_next;
        end
    end

    // ****************************************************************
    // Power-up sequence
    // ****************************************************************
    // Locking starts the reset delay; clocks are ignored until it ends
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            ST_CONFIG: begin
                cnt_next = '0;
                if (locked) begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY: begin
                cnt_next = cnt_reg + DELAY_CNT_W'(1);
                if (cnt_reg == DELAY_CNT_W'(POWERUP_DELAY_CYC - 1)) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: ;
            default: state_next = ST_CONFIG;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_CONFIG;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign init_done = (state_reg == ST_RUN);

    // ****************************************************************
    // Clock generator and keepers
    // ****************************************************************
    bcs_lclk_if lclk ();

    assign lclk.pair_lo = clksel_reg[CLKSEL_PAIR_LO_LSB +: 2];
    assign lclk.pair_hi = clksel_reg[CLKSEL_PAIR_HI_LSB +: 2];
    assign lclk.polarity = clksel_reg[CLKSEL_POL_LSB +: 4];
    assign lclk.pin_as_input = ctrl_reg[CTRL_PIN_IN_LSB +: 4];
    assign lclk.run = init_done;
    assign global_pin_logic = lclk.gpin_logic;
    assign local_clock_level = lclk.level;

    bcs_clock_gen #(
        .TWO_PIN_VARIANT(TWO_PIN_VARIANT)
    ) u_clock_gen (
        .hclk(hclk),
        .hresetn(hresetn),
        .global_clock_pin(global_clock_pin),
        .lclk(lclk.gen)
    );

    bcs_pin_keeper #(
        .N_PINS(N_PINS)
    ) u_pin_keeper (
        .hclk(hclk),
        .hresetn(hresetn),
        .pullup_mode(ctrl_reg[CTRL_PULLUP_BIT]),
        .pad_in(pad_in),
        .pad_driven(pad_driven),
        .keep_out(keep_out),
        .keep_oe_n(keep_oe_n),
        .pad_level(pad_level)
    );

    // ****************************************************************
    // Storage cells
    // ****************************************************************
    genvar c;
    generate
        for (c = 0; c < N_CELLS; c++) begin : g_cell
            logic [1:0] sel;
            logic is_latch;
            assign sel = cell_clk_reg[2*c +: 2];
            assign is_latch = cell_clk_reg[CELLCLK_LATCH_LSB + c];
            // Swap exchanges which block control presets and which clears
            assign eff_set[c] = cell_init_reg[INIT_SWAP_LSB + c] ?
                cell_init_reg[INIT_RST_LSB + c] : cell_init_reg[INIT_SET_LSB + c];
            assign eff_rst[c] = cell_init_reg[INIT_SWAP_LSB + c] ?
                cell_init_reg[INIT_SET_LSB + c] : cell_init_reg[INIT_RST_LSB + c];
            // Before run the cell sits at its power-up value; reset beats preset;
            // an open latch ignores both controls
            assign cell_next[c] =
                !init_done ? eff_set[c] :
                (is_latch && lclk.level[sel]) ? cell_d[c] :
                (eff_rst[c] && block_reset) ? 1'b0 :
                (eff_set[c] && block_preset) ? 1'b1 :
                (!is_latch && lclk.rise[sel]) ? cell_d[c] :
                cell_q_reg[c];

            a_latch_transparent: assert property (@(posedge hclk)
                disable iff (!hresetn)
                (init_done && is_latch && lclk.level[sel]) |=> cell_q_reg[c] == $past(cell_d[c]))
                else $error("open latch did not pass its data");
        end
    endgenerate

    // Low power costs one extra register on the output path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_q_reg <= '0;
            lp_q_reg <= '0;
        end else begin
            cell_q_reg <= cell_next;
            lp_q_reg <= cell_q_reg;
        end
    end

    assign cell_q = ctrl_reg[CTRL_LOWPWR_BIT] ? lp_q_reg : cell_q_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_delay_held;
        (state_reg == ST_DELAY) ##1 (state_reg == ST_DELAY);
    endsequence

    a_powerup_set: assert property (s_delay_held |-> (cell_q_reg & eff_set) == eff_set)
        else $error("set-configured cell not set at power-up");
    a_powerup_clear: assert property (s_delay_held |-> (cell_q_reg & ~eff_set) == '0)
        else $error("cell not cleared at power-up");
    a_swap_init_value: assert property (s_delay_held |-> cell_q_reg == eff_set)
        else $error("swap not applied to power-up value");
    a_delay_length: assert property ($fell(state_reg == ST_DELAY) |->
        $past(cnt_reg) == DELAY_CNT_W'(POWERUP_DELAY_CYC - 1) && init_done)
        else $error("power-up delay of wrong length");
    a_no_edge_in_delay: assert property (!init_done |-> lclk.rise == 4'h0)
        else $error("local clock edge before power-up delay ended");
    a_config_frozen: assert property ((locked && wr_pend_reg) |=>
        $stable(clksel_reg) && $stable(ctrl_reg) && $stable(cell_clk_reg))
        else $error("configuration changed after lock");
    a_lowpower_slower: assert property (ctrl_reg[CTRL_LOWPWR_BIT] ##1
        ctrl_reg[CTRL_LOWPWR_BIT] |-> cell_q == $past(cell_q_reg))
        else $error("low-power path not one cycle slower");
    a_read_answer: assert property ((addr_valid && !hwrite && haddr == 32'(ADDR_CTRL)) |=>
        hrdata == $past(ctrl_reg))
        else $error("control register read wrong");

endmodule : bcs_block_clock

`default_nettype wire

// >>> core/bcs_pkg.sv
// Package: constants and types shared by the block clock and init logic
`default_nettype none

package bcs_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int POWERUP_DELAY_NS = 1000;
    // Least time, so round up to whole cycles
    localparam int POWERUP_DELAY_CYC = (POWERUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_CNT_W = $clog2(POWERUP_DELAY_CYC + 1);

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLKSEL = 8'h04;
    localparam logic [7:0] ADDR_CELL_INIT = 8'h08;
    localparam logic [7:0] ADDR_CELL_CLK = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_PIN_STATUS = 8'h14;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_PULLUP_BIT = 1;
    localparam int CTRL_LOWPWR_BIT = 2;
    localparam int CTRL_PIN_IN_LSB = 4;
    localparam int CLKSEL_PAIR_LO_LSB = 0;
    localparam int CLKSEL_PAIR_HI_LSB = 2;
    localparam int CLKSEL_POL_LSB = 4;
    localparam int INIT_SET_LSB = 0;
    localparam int INIT_RST_LSB = 8;
    localparam int INIT_SWAP_LSB = 16;
    localparam int CELLCLK_LATCH_LSB = 16;
    localparam int STATUS_DONE_BIT = 4;
    localparam int STATUS_Q_LSB = 8;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CLKSEL_RESET = 32'h0000_0000;
    localparam logic [31:0] CELL_INIT_RESET = 32'h0000_0000;
    localparam logic [31:0] CELL_CLK_RESET = 32'h0000_0000;

    // Power-up sequence of the block
    typedef enum logic [1:0] {
        ST_CONFIG = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN = 2'b10
    } bcs_init_state_type;

endpackage : bcs_pkg

`default_nettype wire

// >>> core/bcs_lclk_if.sv
// Interface: configuration into and local clocks out of the clock generator
`default_nettype none

interface bcs_lclk_if;
    logic [1:0] pair_lo;
    logic [1:0] pair_hi;
    logic [3:0] polarity;
    logic [3:0] pin_as_input;
    logic run;
    logic [3:0] level;
    logic [3:0] rise;
    logic [3:0] gpin_logic;

    modport gen (
        input pair_lo, pair_hi, polarity, pin_as_input, run,
        output level, rise, gpin_logic
    );
    modport user (
        output pair_lo, pair_hi, polarity, pin_as_input, run,
        input level, rise, gpin_logic
    );
endinterface : bcs_lclk_if

`default_nettype wire

// >>> core/bcs_clock_gen.sv
// Per-block generator of four local clocks from the global clock pins
`default_nettype none

module bcs_clock_gen
    import bcs_pkg::*;
#(
    parameter bit TWO_PIN_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Global clock pins
    input wire logic [3:0] global_clock_pin,
    // Towards the block
    bcs_lclk_if.gen lclk
);

    logic [3:0] gsync1_reg;
    logic [3:0] gsync2_reg;
    logic [3:0] gpin;
    logic [3:0] gclk_eff;
    logic [3:0] sel_level;
    logic [3:0] level_reg;
    logic [3:0] level_next;

    // Two flops per pin; the first is seen by nothing else
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gsync1_reg <= 4'h0;
            gsync2_reg <= 4'h0;
            level_reg <= 4'h0;
        end else begin
            gsync1_reg <= global_clock_pin;
            gsync2_reg <= gsync1_reg;
            level_reg <= level_next;
        end
    end

    // Small parts bond out two pins only, the upper pair follows the lower
    assign gpin = TWO_PIN_VARIANT ? {gsync2_reg[1:0], gsync2_reg[1:0]} : gsync2_reg;
    // A pin used as logic input never reaches the generator
    assign gclk_eff = gpin & ~lclk.pin_as_input;
    assign lclk.gpin_logic = gpin & lclk.pin_as_input;

    // Fixed pairings: lower pair of local clocks from global 0/1, upper from 2/3
    always_comb begin
        sel_level[0] = gclk_eff[{1'b0, lclk.pair_lo[0]}];
        sel_level[1] = gclk_eff[{1'b0, ~lclk.pair_lo[1]}];
        sel_level[2] = gclk_eff[{1'b1, lclk.pair_hi[0]}];
        sel_level[3] = gclk_eff[{1'b1, ~lclk.pair_hi[1]}];
        level_next = sel_level ^ lclk.polarity;
    end

    // Edge strobes stay quiet until the power-up delay is over
    assign lclk.level = level_reg;
    assign lclk.rise = (level_next & ~level_reg) & {4{lclk.run}};

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_tie_small_pins: assert property (@(posedge hclk) disable iff (!hresetn)
        TWO_PIN_VARIANT |-> gpin[3:2] == gpin[1:0])
        else $error("upper global clocks not tied to lower pair");
    a_input_not_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        (lclk.pin_as_input[3] && !lclk.pair_hi[1]) |=>
        level_reg[3] == $past(lclk.polarity[3]))
        else $error("pin used as input still clocks the block");
    a_rise_follows_level: assert property (@(posedge hclk) disable iff (!hresetn)
        lclk.rise[0] |=> level_reg[0] && !$past(level_reg[0]))
        else $error("local clock strobe without a matching edge");

endmodule : bcs_clock_gen

`default_nettype wire

// >>> core/bcs_pin_keeper.sv
// Weak keeper or pull-up on each input and I/O pin
`default_nettype none

module bcs_pin_keeper
    import bcs_pkg::*;
#(
    parameter int N_PINS = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Mode
    input wire logic pullup_mode,
    // Pad side
    input wire logic [N_PINS-1:0] pad_in,
    input wire logic [N_PINS-1:0] pad_driven,
    output logic [N_PINS-1:0] keep_out,
    output logic [N_PINS-1:0] keep_oe_n,
    // Synchronised pad level
    output logic [N_PINS-1:0] pad_level
);

    logic [N_PINS-1:0] in1_reg;
    logic [N_PINS-1:0] in2_reg;
    logic [N_PINS-1:0] drv1_reg;
    logic [N_PINS-1:0] drv2_reg;
    logic [N_PINS-1:0] hold_reg;
    logic [N_PINS-1:0] hold_next;

    genvar p;
    generate
        for (p = 0; p < N_PINS; p++) begin : g_pin
            // Remember the last level that someone actively drove
            assign hold_next[p] = drv2_reg[p] ? in2_reg[p] : hold_reg[p];
            // Pull-up mode always pulls high; keeper mode holds the last level
            assign keep_out[p] = pullup_mode | hold_reg[p];
            // Weak drive only while the pad is released
            assign keep_oe_n[p] = drv2_reg[p];
        end
    endgenerate

    // Synchronisers and hold latch; keepers start high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in1_reg <= '0;
            in2_reg <= '0;
            drv1_reg <= '0;
            drv2_reg <= '0;
            hold_reg <= '1;
        end else begin
            in1_reg <= pad_in;
            in2_reg <= in1_reg;
            drv1_reg <= pad_driven;
            drv2_reg <= drv1_reg;
            hold_reg <= hold_next;
        end
    end

    // Chosen pin by pin: a vector condition would pick one source for all pins
    assign pad_level = (drv2_reg & in2_reg) | (~drv2_reg & keep_out);

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_keeper_start_high: assert property (@(posedge hclk)
        $rose(hresetn) |-> hold_reg == '1)
        else $error("keeper did not start high");
    a_keeper_holds_last: assert property (@(posedge hclk) disable iff (!hresetn)
        (drv2_reg[0] ##1 !drv2_reg[0]) |-> hold_reg[0] == $past(in2_reg[0], 1))
        else $error("keeper lost the last driven level");
    a_pullup_high: assert property (@(posedge hclk) disable iff (!hresetn)
        pullup_mode |-> keep_out == '1)
        else $error("pull-up mode not pulling high");

endmodule : bcs_pin_keeper

`default_nettype wire

// >>> tb/bcs_board_clk.sv
// Board model driving the global clock pins of the device
`default_nettype none

module bcs_board_clk (
    // Clock
    input wire logic hclk,
    // Control from the bench
    input wire logic clk_enable,
    input wire logic [3:0] pattern,
    // Global clock pins
    output logic [3:0] global_clock_pin = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins stay idle until the bench says the power-up delay is over
    always_ff @(posedge hclk) begin
        global_clock_pin <= clk_enable ? pattern : 4'h0;
    end
endmodule : bcs_board_clk

`default_nettype wire

// >>> tb/tb.sv
// Bench for the block clock select and power-up init logic
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bcs_pkg::*;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout;
    logic init_done;
    logic clk_en = 1'b0;
    logic [3:0] pattern = 4'h0;
    logic [3:0] gpin;
    logic [3:0] gpl;
    logic [3:0] lcl;
    logic [7:0] cell_q;
    logic [7:0] keep_out;
    logic [7:0] keep_oe_n;
    logic [7:0] pad_in = 8'h00;
    logic [7:0] pad_driven = 8'h00;
    logic [7:0] cell_d = 8'h00;
    logic [3:0] lexp [4] = '{4'h0, 4'h3, 4'h6, 4'h2};
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int wait_n;

    // ************************************************************
    // Design and board
    // ************************************************************
    bcs_block_clock dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .global_clock_pin(gpin), .global_pin_logic(gpl),
        .local_clock_level(lcl), .block_preset(1'b0), .block_reset(1'b0),
        .cell_d(cell_d), .cell_q(cell_q), .init_done(init_done),
        .pad_in(pad_in), .pad_driven(pad_driven), .keep_out(keep_out),
        .keep_oe_n(keep_oe_n)
    );
    bcs_board_clk board (
        .hclk(hclk), .clk_enable(clk_en), .pattern(pattern),
        .global_clock_pin(gpin)
    );

    // Clock and hang guard
    initial begin
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 5000) begin
            num_errors++;
            end_sim();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_sim;
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // One single AHB-Lite word transfer; read data lands in rd
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("keep_out", 32'hFF, {24'h0, keep_out});
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, i * 4, 32'h0);
            chk("reset_reg", 32'h0, rd);
        end
        xfer(1'b0, {24'h0, ADDR_PIN_STATUS}, 32'h0);
        chk("pin_status", 32'hFF, rd);
        xfer(1'b0, 32'h200, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Set 0/2, reset 1/3, swap 2/3: power-up value 8'h09
        xfer(1'b1, {24'h0, ADDR_CELL_INIT}, 32'h000C_0A05);
        xfer(1'b1, {24'h0, ADDR_CLKSEL}, 32'h0000_0023);
        // Cell 7 a latch on local 1; lock with low power and pin 3 as input
        xfer(1'b1, {24'h0, ADDR_CELL_CLK}, 32'h0080_4000);
        xfer(1'b1, {24'h0, ADDR_CTRL}, 32'h0000_0085);
        wait_n = 0;
        while (init_done !== 1'b1 && wait_n < 1000) begin
            @(posedge hclk);
            wait_n++;
        end
        // One edge to enter the delay, the delay itself, one edge to see it
        chk("delay", 32'(POWERUP_DELAY_CYC + 2), 32'(wait_n));
        chk("cell_init", 32'h09, {24'h0, cell_q});
        xfer(1'b1, {24'h0, ADDR_CLKSEL}, 32'h0);
        xfer(1'b0, {24'h0, ADDR_CLKSEL}, 32'h0);
        chk("clksel_lock", 32'h23, rd);
        clk_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pattern <= 4'h1 << i;
            repeat (6) @(posedge hclk);
            chk("local_lvl", {28'h0, lexp[i]}, {28'h0, lcl});
            chk("gpin_logic", (i == 3) ? 32'h8 : 32'h0, {28'h0, gpl});
        end
        chk("cell_edge", 32'h0, {24'h0, cell_q});
        // Local 1 is high now, so the latch of cell 7 is open
        cell_d <= 8'h80;
        repeat (2) @(posedge hclk);
        chk("lowpwr_lag", 32'h0, {24'h0, cell_q});
        @(posedge hclk);
        chk("cell_latch", 32'h80, {24'h0, cell_q});
        pad_in <= 8'h5A;
        pad_driven <= 8'hFF;
        repeat (5) @(posedge hclk);
        chk("oe_driven", 32'hFF, {24'h0, keep_oe_n});
        // Upper pins stay driven, lower ones keep their last level
        pad_driven <= 8'hF0;
        pad_in <= 8'hA5;
        repeat (5) @(posedge hclk);
        chk("keep_lvl", 32'hAA, {24'h0, keep_out});
        chk("oe_keep", 32'hF0, {24'h0, keep_oe_n});
        xfer(1'b0, {24'h0, ADDR_PIN_STATUS}, 32'h0);
        chk("pin_keep", 32'hAA, rd);
        end_sim();
    end
endmodule : tb

`default_nettype wire
